// ==== cci_consts.vh ====
/*
 * constants of the configuration command interpreter: command codes,
 * framing words, field positions, apb offsets, reset values, timing.
 * assumes inclusion by bare name from the design files.
 */
`ifndef CCI_CONSTS_VH
`define CCI_CONSTS_VH

// idle filler values and framing words
`define CCI_IDLE_A      8'h00
`define CCI_IDLE_B      8'h7f
`define CCI_IDLE_C      8'hff
`define CCI_ALL_ONES    32'hffffffff
`define CCI_MARKER      32'h0fffff00
`define CCI_FILL_BYTE   8'hff
`define CCI_START_BYTE  8'h00
`define CCI_WREN        8'h06
`define CCI_LEN_MAX     8'd9

// first command byte
`define CCI_OP_READ     8'h01
`define CCI_OP_FRAME    8'h0a
`define CCI_OP_PORT     8'h7a
`define CCI_OP_PSTAT    8'h7b
`define CCI_OP_CTRL     8'h80

// read subcodes and control codes
`define CCI_SUB_ST0     8'h07
`define CCI_SUB_ST1     8'h08
`define CCI_SUB_ST2     8'h09
`define CCI_SUB_ST3     8'h0a
`define CCI_SUB_ST4     8'h0e
`define CCI_SUB_BUSY    8'h0b
`define CCI_CTL_REFRESH 8'h0a
`define CCI_CTL_LANE    8'h0f

// port request types and owners
`define CCI_REQ_NOWAIT  2'b00
`define CCI_REQ_WAIT    2'b01
`define CCI_REQ_FORCE   2'b10
`define CCI_REQ_RELEASE 2'b11
`define CCI_OWN_NONE    2'd0
`define CCI_OWN_JT      2'd1
`define CCI_OWN_SP      2'd2

// target port lane modes
`define CCI_LANE_X1     2'b00
`define CCI_LANE_X8     2'b11

// boot mode fields
`define CCI_BM_TYPE     15:9
`define CCI_BM_DIFF     8
`define CCI_BM_DIV      7:2
`define CCI_BM_SRC      1:0
`define CCI_BT_OCT1     7'd4
`define CCI_BT_OCT2     7'd5
`define CCI_BM_RESET    16'h0000

// apb map and reset values
`define CCI_A_CTRL      12'h000
`define CCI_A_STATUS    12'h004
`define CCI_A_FRAME     12'h008
`define CCI_CTRL_RESET  2'b11

// port wait timeout
`define CCI_WAIT_CYC    24'd100000

`endif

// ==== cci_cmd_port.v ====
/*
 * one client interface: assembles four-byte commands from a byte stream,
 * skipping idle filler, and holds a four-word result fifo of its own.
 * assumes bytes arrive synchronous to mclk, one per valid cycle.
 */
`timescale 1ns/1ps
`include "cci_consts.vh"

module cci_cmd_port (
  // clock and reset
  input  wire        mclk,
  input  wire        reset,
  // incoming command bytes
  input  wire        byte_valid,
  input  wire [7:0]  byte_in,
  input  wire        accept,
  // assembled command
  output reg         cmd_valid,
  output reg  [31:0] cmd_word,
  input  wire        cmd_take,
  // result fifo
  input  wire        push,
  input  wire [31:0] push_word,
  output wire        full,
  input  wire        pop,
  output wire [31:0] head,
  output wire        empty
);

  reg [1:0]  cnt_reg;
  reg [23:0] asm_reg;
  reg [31:0] mem_reg [0:3];
  reg [1:0]  wr_reg;
  reg [1:0]  rd_reg;
  reg [2:0]  num_reg;
  wire       filler;

  assign filler = (byte_in == `CCI_IDLE_A) || (byte_in == `CCI_IDLE_B) ||
                  (byte_in == `CCI_IDLE_C);

  // byte assembly; a filler at a command boundary is dropped
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_reg   <= 2'd0;
      asm_reg   <= 24'h0;
      cmd_valid <= 1'b0;
      cmd_word  <= 32'h0;
    end else begin
      if (cmd_take)
        cmd_valid <= 1'b0;
      if (byte_valid && accept && !cmd_valid) begin
        if (!(cnt_reg == 2'd0 && filler)) begin
          asm_reg <= {asm_reg[15:0], byte_in};
          cnt_reg <= cnt_reg + 2'd1;
          if (cnt_reg == 2'd3) begin
            cmd_valid <= 1'b1;
            cmd_word  <= {asm_reg, byte_in};
          end
        end
      end
    end
  end

  assign full  = (num_reg == 3'd4);
  assign empty = (num_reg == 3'd0);
  assign head  = mem_reg[rd_reg];

  // result fifo private to this interface
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_reg  <= 2'd0;
      rd_reg  <= 2'd0;
      num_reg <= 3'd0;
    end else begin
      if (push && !full) begin
        mem_reg[wr_reg] <= push_word;
        wr_reg          <= wr_reg + 2'd1;
      end
      if (pop && !empty)
        rd_reg <= rd_reg + 2'd1;
      num_reg <= num_reg + {2'd0, push && !full} - {2'd0, pop && !empty};
    end
  end

endmodule // cci_cmd_port

// ==== cci_top.v ====
/*
 * configuration command interpreter: takes commands from a jtag client
 * and a target serial client, answers reads per client, arbitrates port
 * ownership, and runs target lane and boot flash mode changes.
 * assumes all inputs synchronous to mclk and frame_rdata valid while
 * frame_rd is high.
 */
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "cci_consts.vh"

// How it works
// - read results go back through the interface that sent the command
// - jtag capture gives all ones while no result is waiting
// - jtag capture gives marker, then result words, then all ones again
// - serial port drives ones in x1 and floats in wider modes until ready
// - narrow modes send at least one ff byte then a 00 start byte
// - octal mode raises strobe with the ff byte, then sends 00, giving an ff00 start word
// - serial data lines float when select is high, or when results are empty except for x1 fill bytes
// - frame readback on the serial port only in single lane mode
// - commands are four bytes; single idle filler bytes are skipped
// - opcode 01 returns status words or busy flag chosen by subcode
// - reconfigure control command acts like toggling program request
// - port request accepted everywhere; owner locks out other clients
// - request types: try, wait with timeout, force, release
// - boot flash mode equal to current one does nothing; starts x1
// - new boot mode stops reading, sends sequence, switches, reconfigures
// - length 1..9 sends write enable, then that many bytes; else none
// - boot mode bits 15:9 give the flash read type
// - bit 8 differential clock for octal, 7:2 divider, 1:0 source
// - target lane mode command sets lanes from operand bits 1:0
// - frame readback reads frame_count frames and advances the address
module cci_top #(
  parameter [23:0] WAIT_CYCLES = `CCI_WAIT_CYC
) (
  // clock and reset
  input  wire         mclk,
  input  wire         reset,
  // apb slave
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [11:0]  paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output reg          pready,
  output reg          pslverr,
  // jtag client
  input  wire         jt_byte_valid,
  input  wire [7:0]   jt_byte,
  input  wire         jt_capture,
  output reg  [31:0]  jt_capture_word,
  // target serial port client
  input  wire         sp_csn,
  input  wire         sp_byte_valid,
  input  wire [7:0]   sp_byte,
  input  wire         sp_byte_req,
  output reg  [7:0]   sp_out_byte,
  output reg          sp_out_oe,
  output reg          sp_strobe_en,
  output reg  [1:0]   sp_lane_mode,
  // device state and frames
  input  wire [159:0] status_words,
  output reg  [31:0]  frame_addr,
  output reg          frame_rd,
  input  wire [31:0]  frame_rdata,
  // reconfigure
  input  wire         program_request_pin_n,
  output reg          refresh,
  // boot flash mode command from the bitstream
  input  wire         bs_mode_valid,
  input  wire [15:0]  bs_mode,
  input  wire [7:0]   bs_cmd_len,
  input  wire [71:0]  bs_cmd_data,
  // boot flash port
  output reg          flash_read_en,
  output reg          flash_tx_valid,
  output reg  [7:0]   flash_tx_byte,
  output reg          flash_tx_last,
  input  wire         flash_tx_ready,
  output reg  [15:0]  boot_mode,
  output reg          boot_diff_clk
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_PUSH  = 3'b010;
  localparam ST_FRAME = 3'b100;
  localparam SP_FILL  = 3'b001;
  localparam SP_HALF  = 3'b010;
  localparam SP_DATA  = 3'b100;
  localparam FL_IDLE  = 4'b0001;
  localparam FL_WREN  = 4'b0010;
  localparam FL_DATA  = 4'b0100;
  localparam FL_DONE  = 4'b1000;

  reg  [2:0]  state_reg;
  reg         src_reg;
  reg  [31:0] res_reg;
  reg  [15:0] nfr_reg;
  reg  [1:0]  owner_reg;
  reg         wt_pend_reg;
  reg  [1:0]  wt_port_reg;
  reg  [1:0]  wt_held_reg;
  reg  [23:0] wt_cnt_reg;
  reg  [1:0]  ctrl_reg;
  reg         prog_q_reg;
  reg         jt_mark_reg;
  reg  [2:0]  sp_state_reg;
  reg         sp_fill_reg;
  reg  [1:0]  sp_idx_reg;
  reg  [3:0]  fl_state_reg;
  reg  [15:0] fl_mode_reg;
  reg  [3:0]  fl_len_reg;
  reg  [71:0] fl_shift_reg;
  reg  [31:0] read_word;
  reg  [31:0] apb_word;

  wire        jt_cmd_valid;
  wire [31:0] jt_cmd;
  wire        jt_full;
  wire        jt_empty;
  wire [31:0] jt_head;
  wire        sp_cmd_valid;
  wire [31:0] sp_cmd;
  wire        sp_full;
  wire        sp_empty;
  wire [31:0] sp_head;

  wire        st_idle   = (state_reg == ST_IDLE);
  wire        any_cmd   = jt_cmd_valid | sp_cmd_valid;
  wire        cur_src   = ~jt_cmd_valid;
  wire [31:0] cw        = jt_cmd_valid ? jt_cmd : sp_cmd;
  wire [1:0]  me        = cur_src ? `CCI_OWN_SP : `CCI_OWN_JT;
  wire        dst_full  = src_reg ? sp_full : jt_full;
  wire        push_any  = (state_reg == ST_PUSH && !dst_full) || frame_rd;
  wire [31:0] push_word = frame_rd ? frame_rdata : res_reg;
  wire        fl_busy   = (fl_state_reg != FL_IDLE);
  wire        stream_jt = (state_reg == ST_FRAME) && !src_reg;
  wire        stream_sp = (state_reg == ST_FRAME) && src_reg;
  wire        sp_req    = sp_byte_req && !sp_csn;
  wire        jt_pop    = jt_capture && jt_mark_reg && !jt_empty;
  wire        sp_pop    = sp_req && (sp_state_reg == SP_DATA) && !sp_empty &&
                          (sp_idx_reg == 2'd3);
  wire [31:0] sp_shift  = sp_head << {sp_idx_reg, 3'b000};
  wire        apb_wr    = psel && penable && pready && pwrite;
  wire        prog_rise = program_request_pin_n && !prog_q_reg;

  // clients are heard only while enabled and not locked out by an owner
  wire jt_accept = ctrl_reg[0] && (owner_reg == `CCI_OWN_NONE ||
                   owner_reg == `CCI_OWN_JT);
  wire sp_accept = ctrl_reg[1] && (owner_reg == `CCI_OWN_NONE ||
                   owner_reg == `CCI_OWN_SP);

  cci_cmd_port u_jt (
    .mclk       (mclk),
    .reset      (reset),
    .byte_valid (jt_byte_valid),
    .byte_in    (jt_byte),
    .accept     (jt_accept),
    .cmd_valid  (jt_cmd_valid),
    .cmd_word   (jt_cmd),
    .cmd_take   (st_idle),
    .push       (push_any && !src_reg),
    .push_word  (push_word),
    .full       (jt_full),
    .pop        (jt_pop),
    .head       (jt_head),
    .empty      (jt_empty)
  );

  cci_cmd_port u_sp (
    .mclk       (mclk),
    .reset      (reset),
    .byte_valid (sp_byte_valid),
    .byte_in    (sp_byte),
    .accept     (sp_accept),
    .cmd_valid  (sp_cmd_valid),
    .cmd_word   (sp_cmd),
    .cmd_take   (st_idle && !jt_cmd_valid),
    .push       (push_any && src_reg),
    .push_word  (push_word),
    .full       (sp_full),
    .pop        (sp_pop),
    .head       (sp_head),
    .empty      (sp_empty)
  );

  // four-byte answer to an opcode 01 read
  always @* begin
    case (cw[23:16])
      `CCI_SUB_ST0:  read_word = status_words[31:0];
      `CCI_SUB_ST1:  read_word = status_words[63:32];
      `CCI_SUB_ST2:  read_word = status_words[95:64];
      `CCI_SUB_ST3:  read_word = status_words[127:96];
      `CCI_SUB_ST4:  read_word = status_words[159:128];
      `CCI_SUB_BUSY: read_word = {31'h0, fl_busy};
      default:       read_word = 32'h0;
    endcase
  end

  // command engine, port ownership, frame readback and reconfigure
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg    <= ST_IDLE;
      src_reg      <= 1'b0;
      res_reg      <= 32'h0;
      nfr_reg      <= 16'h0;
      owner_reg    <= `CCI_OWN_NONE;
      wt_pend_reg  <= 1'b0;
      wt_port_reg  <= `CCI_OWN_NONE;
      wt_held_reg  <= `CCI_OWN_NONE;
      wt_cnt_reg   <= 24'h0;
      sp_lane_mode <= `CCI_LANE_X1;
      frame_addr   <= 32'h0;
      frame_rd     <= 1'b0;
      refresh      <= 1'b0;
      prog_q_reg   <= 1'b1;
    end else begin
      prog_q_reg <= program_request_pin_n;
      refresh    <= prog_rise || (fl_state_reg == FL_DONE);
      frame_rd   <= 1'b0;
      // a waiting request ends on grant, on another grant or on timeout
      if (wt_pend_reg) begin
        wt_cnt_reg <= wt_cnt_reg + 24'd1;
        if (owner_reg == `CCI_OWN_NONE) begin
          owner_reg   <= wt_port_reg;
          wt_pend_reg <= 1'b0;
        end else if (owner_reg != wt_held_reg ||
                     wt_cnt_reg == WAIT_CYCLES - 24'd1)
          wt_pend_reg <= 1'b0;
      end
      if (apb_wr && paddr == `CCI_A_FRAME)
        frame_addr <= pwdata;
      else if (frame_rd)
        frame_addr <= frame_addr + 32'd1;
      case (state_reg)
        ST_IDLE: begin
          if (any_cmd) begin
            src_reg <= cur_src;
            case (cw[31:24])
              `CCI_OP_READ: begin
                res_reg   <= read_word;
                state_reg <= ST_PUSH;
              end
              `CCI_OP_PSTAT: begin
                res_reg   <= {30'h0, owner_reg};
                state_reg <= ST_PUSH;
              end
              `CCI_OP_FRAME: begin
                if (!cur_src || sp_lane_mode == `CCI_LANE_X1) begin
                  nfr_reg   <= cw[15:0];
                  state_reg <= ST_FRAME;
                end
              end
              `CCI_OP_PORT: begin
                case (cw[1:0])
                  `CCI_REQ_NOWAIT: begin
                    if (owner_reg == `CCI_OWN_NONE)
                      owner_reg <= me;
                  end
                  `CCI_REQ_WAIT: begin
                    if (owner_reg == `CCI_OWN_NONE)
                      owner_reg <= me;
                    else if (owner_reg != me) begin
                      wt_pend_reg <= 1'b1;
                      wt_port_reg <= me;
                      wt_held_reg <= owner_reg;
                      wt_cnt_reg  <= 24'h0;
                    end
                  end
                  `CCI_REQ_FORCE: owner_reg <= me;
                  default:        owner_reg <= `CCI_OWN_NONE;
                endcase
              end
              `CCI_OP_CTRL: begin
                if (cw[15:8] == `CCI_CTL_REFRESH) begin
                  refresh   <= 1'b1;
                  owner_reg <= `CCI_OWN_NONE;
                end else if (cw[15:8] == `CCI_CTL_LANE)
                  sp_lane_mode <= cw[1:0];
              end
              default: ;
            endcase
          end
        end
        ST_PUSH: begin
          if (!dst_full)
            state_reg <= ST_IDLE;
        end
        ST_FRAME: begin
          if (frame_rd)
            nfr_reg <= nfr_reg - 16'd1;
          else if (nfr_reg == 16'h0)
            state_reg <= ST_IDLE;
          else if (!dst_full)
            frame_rd <= 1'b1;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // jtag capture word: ones, marker, result words, ones again
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      jt_capture_word <= `CCI_ALL_ONES;
      jt_mark_reg     <= 1'b0;
    end else if (jt_capture) begin
      if (!jt_mark_reg && !jt_empty) begin
        jt_capture_word <= `CCI_MARKER;
        jt_mark_reg     <= 1'b1;
      end else if (jt_mark_reg && !jt_empty)
        jt_capture_word <= jt_head;
      else begin
        jt_capture_word <= `CCI_ALL_ONES;
        if (!stream_jt)
          jt_mark_reg <= 1'b0;
      end
    end
  end

  // serial output: fill bytes, start byte or word, then result bytes
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      sp_state_reg <= SP_FILL;
      sp_fill_reg  <= 1'b0;
      sp_idx_reg   <= 2'd0;
      sp_out_byte  <= `CCI_FILL_BYTE;
      sp_out_oe    <= 1'b0;
      sp_strobe_en <= 1'b0;
    end else if (sp_csn)
      sp_out_oe <= 1'b0;
    else if (sp_byte_req) begin
      case (sp_state_reg)
        SP_FILL: begin
          if (sp_fill_reg && !sp_empty) begin
            sp_out_oe   <= 1'b1;
            sp_fill_reg <= 1'b0;
            if (sp_lane_mode == `CCI_LANE_X8) begin
              sp_out_byte  <= `CCI_FILL_BYTE;
              sp_strobe_en <= 1'b1;
              sp_state_reg <= SP_HALF;
            end else begin
              sp_out_byte  <= `CCI_START_BYTE;
              sp_state_reg <= SP_DATA;
            end
          end else begin
            sp_out_byte  <= `CCI_FILL_BYTE;
            sp_out_oe    <= (sp_lane_mode == `CCI_LANE_X1);
            sp_strobe_en <= 1'b0;
            sp_fill_reg  <= 1'b1;
          end
        end
        SP_HALF: begin
          sp_out_byte  <= `CCI_START_BYTE;
          sp_state_reg <= SP_DATA;
        end
        SP_DATA: begin
          if (!sp_empty) begin
            sp_out_byte <= sp_shift[31:24];
            sp_out_oe   <= 1'b1;
            sp_idx_reg  <= sp_idx_reg + 2'd1;
          end else begin
            sp_out_oe <= 1'b0;
            if (!stream_sp) begin
              sp_state_reg <= SP_FILL;
              sp_strobe_en <= 1'b0;
            end
          end
        end
        default: sp_state_reg <= SP_FILL;
      endcase
    end
  end

  // boot flash mode change sequence
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      fl_state_reg   <= FL_IDLE;
      fl_mode_reg    <= `CCI_BM_RESET;
      fl_len_reg     <= 4'd0;
      fl_shift_reg   <= 72'h0;
      boot_mode      <= `CCI_BM_RESET;
      boot_diff_clk  <= 1'b0;
      flash_read_en  <= 1'b1;
      flash_tx_valid <= 1'b0;
      flash_tx_byte  <= 8'h0;
      flash_tx_last  <= 1'b0;
    end else begin
      case (fl_state_reg)
        FL_IDLE: begin
          if (bs_mode_valid && bs_mode != boot_mode) begin
            flash_read_en <= 1'b0;
            fl_mode_reg   <= bs_mode;
            fl_shift_reg  <= bs_cmd_data;
            fl_len_reg    <= bs_cmd_len[3:0];
            if (bs_cmd_len != 8'd0 && bs_cmd_len <= `CCI_LEN_MAX) begin
              flash_tx_valid <= 1'b1;
              flash_tx_byte  <= `CCI_WREN;
              flash_tx_last  <= 1'b1;
              fl_state_reg   <= FL_WREN;
            end else
              fl_state_reg <= FL_DONE;
          end
        end
        FL_WREN, FL_DATA: begin
          if (flash_tx_ready) begin
            if (flash_tx_last && fl_state_reg == FL_DATA) begin
              flash_tx_valid <= 1'b0;
              fl_state_reg   <= FL_DONE;
            end else begin
              flash_tx_byte <= fl_shift_reg[7:0];
              fl_shift_reg  <= {8'h0, fl_shift_reg[71:8]};
              flash_tx_last <= (fl_len_reg == 4'd1);
              fl_len_reg    <= fl_len_reg - 4'd1;
              fl_state_reg  <= FL_DATA;
            end
          end
        end
        FL_DONE: begin
          boot_mode     <= fl_mode_reg;
          boot_diff_clk <= fl_mode_reg[`CCI_BM_DIFF] &&
                           (fl_mode_reg[`CCI_BM_TYPE] == `CCI_BT_OCT1 ||
                            fl_mode_reg[`CCI_BM_TYPE] == `CCI_BT_OCT2);
          flash_read_en <= 1'b1;
          fl_state_reg  <= FL_IDLE;
        end
        default: fl_state_reg <= FL_IDLE;
      endcase
    end
  end

  // apb read data mux
  always @* begin
    case (paddr)
      `CCI_A_CTRL:   apb_word = {30'h0, ctrl_reg};
      `CCI_A_STATUS: apb_word = {10'h0, fl_busy, wt_pend_reg, owner_reg,
                                 sp_lane_mode, boot_mode};
      `CCI_A_FRAME:  apb_word = frame_addr;
      default:       apb_word = 32'h0;
    endcase
  end

  // apb slave: one access cycle, error on unmapped address
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      ctrl_reg <= `CCI_CTRL_RESET;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr != `CCI_A_CTRL &&
                 paddr != `CCI_A_STATUS && paddr != `CCI_A_FRAME;
      if (psel && !penable)
        prdata <= apb_word;
      if (apb_wr && paddr == `CCI_A_CTRL)
        ctrl_reg <= pwdata[1:0];
    end
  end

endmodule // cci_top

// ==== cci_top_checker.sv ====
/* assertions on cci_top ports: apb answer, pulses, serial float, capture, boot.
 * assumes a bind onto cci_top; reset is async and active high. */
`timescale 1ns/1ps
module cci_top_checker (
  // clock and reset
  input wire        mclk,
  input wire        reset,
  // apb
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // clients
  input wire        jt_capture,
  input wire [31:0] jt_capture_word,
  input wire        sp_csn,
  input wire        sp_out_oe,
  // frames, refresh, boot
  input wire        frame_rd,
  input wire [31:0] frame_addr,
  input wire        refresh,
  input wire [15:0] boot_mode,
  input wire        boot_diff_clk
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // apb phases
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  // properties
  chk_apb_ready: assert property (s_setup |=> pready) else $error("no ready after setup");
  chk_ready_once: assert property (pready |=> !pready) else $error("ready too long");
  chk_bad_addr: assert property (s_access |-> pslverr == !(paddr inside {0, 4, 8}))
    else $error("error flag wrong");
  chk_refresh_once: assert property (refresh |=> !refresh) else $error("long refresh");
  chk_frame_step: assert property (frame_rd |=> frame_addr == $past(frame_addr) + 32'h1)
    else $error("frame address step");
  chk_csn_float: assert property (sp_csn [*3] |-> !sp_out_oe) else $error("drives off");
  chk_capture_hold: assert property ($changed(jt_capture_word) |-> $past(jt_capture))
    else $error("capture word moved");
  chk_diff_octal: assert property (boot_diff_clk |-> boot_mode[15:9] inside {7'd4, 7'd5})
    else $error("differential clock");
endmodule // cci_top_checker
bind cci_top cci_top_checker i_chk (.*);

// ==== cci_host.sv ====
/* host model: jtag and target serial client at byte level.
 * assumes its tasks are called right after a rising mclk edge. */
`timescale 1ns/1ps
module cci_host (
  // clock
  input wire        mclk,
  // jtag client
  output reg        jt_byte_valid = 1'b0,
  output reg [7:0]  jt_byte = 8'h00,
  output reg        jt_capture = 1'b0,
  // target serial client
  output reg        sp_csn = 1'b1,
  output reg        sp_byte_valid = 1'b0,
  output reg [7:0]  sp_byte = 8'h00,
  output reg        sp_byte_req = 1'b0
);
  // one command, msb first, then wait out the worst latency
  task send(input bit sp, input logic [31:0] w);
    for (int i = 3; i >= 0; i--) begin
      jt_byte_valid <= !sp;
      sp_byte_valid <= sp;
      jt_byte       <= w[8*i +: 8];
      sp_byte       <= w[8*i +: 8];
      @(posedge mclk);
    end
    jt_byte_valid <= 1'b0;
    sp_byte_valid <= 1'b0;
    jt_byte       <= ~jt_byte;
    sp_byte       <= 8'h00; // zeros while the answer comes
    repeat (8) @(posedge mclk);
  endtask
  // one capture or one output byte request; caller judges the first serial byte
  task pulse(input bit sp);
    jt_capture  <= !sp;
    sp_byte_req <= sp;
    @(posedge mclk);
    jt_capture  <= 1'b0;
    sp_byte_req <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // chip select level
  task sel(input bit v);
    sp_csn <= v;
    @(posedge mclk);
  endtask
endmodule // cci_host

// ==== tb.sv ====
/* bench for cci_top: apb table, reads on both clients, lanes, ownership,
 * frames, refresh, boot flash change; cci_host drives the clients. */
`timescale 1ns/1ps
module tb;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, x; logic e;} cci_row_t;
  // apb side
  logic        mclk = 1'b0, reset, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, jt_capture_word, frame_addr;
  logic        pready, pslverr, er, jt_byte_valid, jt_capture, sp_csn, sp_byte_valid;
  logic [7:0]  jt_byte, sp_byte, sp_out_byte, flash_tx_byte, bs_cmd_len;
  logic        sp_byte_req, sp_out_oe, sp_strobe_en, frame_rd, refresh;
  logic [1:0]  sp_lane_mode;
  // stand-ins for the fabric; frame data follows the address
  logic [159:0] status_words;
  wire [31:0]  frame_rdata = {16'h0f0e, frame_addr[15:0]};
  logic        program_request_pin_n;
  // boot flash side
  logic        bs_mode_valid, flash_tx_ready = 1'b0, flash_read_en;
  logic [15:0] bs_mode, boot_mode;
  logic [71:0] bs_cmd_data;
  logic        flash_tx_valid, flash_tx_last, boot_diff_clk;
  // bench state
  logic [7:0]  fq[$];
  logic [7:0]  sub[6] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0e, 8'h0b};
  logic [47:0] exp_b;
  int          n_fail = 0, n_checks = 0, n_ref = 0, k;
  cci_row_t    rows[5] = '{'{0, 12'h000, 0, 3, 0}, '{1, 12'h008, 5, 0, 0},
                  '{0, 12'h008, 0, 5, 0}, '{0, 12'h004, 0, 0, 0}, '{0, 12'h00c, 0, 0, 1}};
  cci_top #(.WAIT_CYCLES(24'd20)) i_dut (.*);
  cci_host i_host (.*);
  // clock, stalling flash, and monitors
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    flash_tx_ready <= ~flash_tx_ready;
    if (flash_tx_valid && flash_tx_ready) fq.push_back(flash_tx_byte);
    if (refresh) n_ref++;
  end
  // compare and verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer, held until ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // watchdog: the sequence needs under 2000 cycles
  initial begin
    #50000;
    n_fail++;
    close_out;
  end
  initial begin
    reset <= 1'b1;
    {psel, penable, pwrite, paddr, pwdata, bs_mode_valid} <= '0;
    {bs_mode, bs_cmd_len, bs_cmd_data, program_request_pin_n} <= 97'h1;
    status_words <= {32'h55555555, 32'h44444444, 32'h33333333, 32'h22222222, 32'h11111111};
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].x);
      chk(er, rows[i].e);
    end
    i_host.pulse(0);
    chk(jt_capture_word, 32'hffffffff);
    foreach (sub[i]) begin
      i_host.send(0, {8'h01, sub[i], 16'h0});
      i_host.pulse(0);
      chk(jt_capture_word, 32'h0fffff00);
      i_host.pulse(0);
      chk(jt_capture_word, i < 5 ? 32'h11111111 * (i + 1) : 0);
      i_host.pulse(0);
      chk(jt_capture_word, 32'hffffffff);
    end
    // serial x1 read: fill, start byte, word, then float
    i_host.sel(0);
    i_host.send(1, 32'h01080000);
    exp_b = {8'hff, 8'h00, 32'h22222222};
    for (int i = 5; i >= 0; i--) begin
      i_host.pulse(1);
      chk({sp_out_oe, sp_out_byte}, {1'b1, exp_b[8*i +: 8]});
    end
    i_host.pulse(1);
    chk(sp_out_oe, 0);
    // every lane mode; frame readback refused on the serial port in x2
    for (int m = 3; m >= 0; m--) begin
      i_host.send(0, {24'h80000f, 6'h0, m[1:0]});
      chk(sp_lane_mode, m);
      if (m == 1) i_host.send(1, 32'h0a000001);
      if (m == 1) chk(frame_addr, 5);
    end
    i_host.send(0, 32'h0a000001);
    chk(frame_addr, 6);
    i_host.pulse(0);
    i_host.pulse(0);
    chk(jt_capture_word, 32'h0f0e0005);
    // serial forces ownership, jtag is shut out, then release
    i_host.send(1, 32'h7a000002);
    i_host.send(0, 32'h80000f01);
    chk(sp_lane_mode, 0);
    apb(0, 12'h004, 0);
    chk(rd, 32'h00080000);
    i_host.send(1, 32'h7a000003);
    i_host.sel(1);
    apb(0, 12'h004, 0);
    chk(rd, 0);
    k = n_ref;
    i_host.send(0, 32'h80000a00);
    chk(n_ref, k + 1);
    program_request_pin_n <= 1'b0;
    @(posedge mclk);
    program_request_pin_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(n_ref, k + 2);
    // new octal boot mode, then the same mode again
    bs_mode <= 16'h0903;
    bs_cmd_len <= 8'd2;
    bs_cmd_data <= 72'hbbaa;
    repeat (2) begin
      bs_mode_valid <= 1'b1;
      @(posedge mclk);
      bs_mode_valid <= 1'b0;
      repeat (40) @(posedge mclk);
    end
    chk(fq.size(), 3);
    chk({fq[0], fq[1], fq[2]}, 24'h06aabb);
    chk(boot_mode, 16'h0903);
    chk(boot_diff_clk, 1);
    chk(n_ref, k + 3);
    chk(flash_read_en, 1);
    // reset in mid-run: boot port back to x1 default, capture back to ones
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({boot_mode, jt_capture_word[15:0]}, 32'hffff);
    close_out;
  end
endmodule // tb
